// ---- bench/scc_spi_host.sv ----
// Serial host model sending 8-bit frames, MSB first.
// Assumes the block samples the pins on clk.
module scc_spi_host
(
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Whole frames of exactly eight bits, idle clock low.
  task automatic xfer(input logic [7:0] tx, input int half,
                      output logic [7:0] rx);
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      repeat (half) @(posedge clk);
      #1 rx[i] = miso;
      sclk = 1'b1;
      repeat (half) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (half) @(posedge clk);
    #1 cs_n = 1'b1;
    mosi = ~mosi;
    repeat (7) @(posedge clk);
    #1;
  endtask
endmodule

// ---- bench/scc_top_asserts.sv ----
// Checker on the ports of the switch channel control top.
// Assumes one clock and a synchronous reset.
module scc_top_asserts
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Serial pins
  input wire logic                    sclk,
  input wire logic                    cs_n,
  input wire logic                    mosi,
  input wire logic                    miso,
  input wire logic                    miso_oe,
  // Channel pins
  input wire logic [CHANNELS-1:0]     channel_input_pin,
  input wire logic                    limp_home_input,
  input wire logic [CHANNELS-1:0]     channel_output,
  input wire logic [LED_CHANNELS-1:0] led_load_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] pin_cnt;
  logic [2:0] limp_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_idle;
    cs_n [*3];
  endsequence
  sequence s_sel;
    !cs_n [*3];
  endsequence
  always_ff @(posedge clk)
  begin
    if (sys_rst || !$stable(channel_input_pin))
      pin_cnt <= 3'h0;
    else if (pin_cnt != 3'h7)
      pin_cnt <= pin_cnt + 3'h1;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || !limp_home_input)
      limp_cnt <= 3'h0;
    else if (limp_cnt != 3'h7)
      limp_cnt <= limp_cnt + 3'h1;
  end
  AST_RST_OUT: assert property (disable iff (1'b0)
    sys_rst |=> channel_output == 6'h00) else $error("out not cleared");
  AST_RST_LED: assert property (disable iff (1'b0)
    sys_rst |=> led_load_select == 3'h0) else $error("led not cleared");
  AST_RST_OE: assert property (disable iff (1'b0)
    sys_rst |=> !miso_oe) else $error("miso enabled in reset");
  AST_OE_OFF: assert property (s_idle |-> !miso_oe)
    else $error("miso enabled while idle");
  AST_OE_ON: assert property (s_sel |-> miso_oe)
    else $error("miso not enabled in frame");
  AST_LIMP_OUT: assert property (limp_cnt == 3'h7 && pin_cnt > 3'h3
    |-> channel_output == channel_input_pin) else $error("limp out");
  AST_LIMP_REG: assert property (limp_cnt == 3'h7
    |-> led_load_select == LED_RESET) else $error("limp reg");
  AST_LED_FRAME: assert property ($changed(led_load_select)
    |-> $past(cs_n) && $past(cs_n, 2)) else $error("led moved in frame");
endmodule

// ---- bench/scc_top_tb_top.sv ----
// Testbench of the switch channel control top with a serial host.
// Assumes a 100 MHz clock and the checker bound to the top.
module scc_top_tb_top
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic limp_home_input = 1'b0;
  logic [5:0] channel_input_pin = 6'h00;
  logic [5:0] channel_output, cmd, pin;
  logic [2:0] led_load_select, led;
  logic [7:0] rx;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 32'hb820;
  always #5 clk = ~clk;
  scc_top scc_top_inst (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .channel_input_pin(channel_input_pin),
    .limp_home_input(limp_home_input), .channel_output(channel_output),
    .led_load_select(led_load_select));
  scc_spi_host scc_spi_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));
  function automatic logic [5:0] mix(logic [5:0] c, p, logic g);
    return g ? (c & p) : (c | p);
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xf(input logic [7:0] w);
    scc_spi_host_inst.xfer(w, 3 + $unsigned($random(seed)) % 3, rx);
  endtask
  task automatic rd(input logic [7:0] w);
    xf(w);
    xf(8'h00);
  endtask
  task automatic pins(input logic [5:0] v);
    @(posedge clk) #1 channel_input_pin = v;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("out", 8'h00, {2'h0, channel_output});
    xf(8'h60);
    chk("first", 8'h00, {1'b0, rx[6:0]});
    xf(8'h00);
    chk("hw", 8'h66, {1'b0, rx[6:0]});
    xf(8'hE0);
    for (int g = 0; g < 2; g++)
    begin
      xf(8'h80);
      pins(6'h00);
      led = $random(seed);
      xf({4'hC, g[0], led});
      chk("led", {5'h00, led}, {5'h00, led_load_select});
      for (int i = 0; i < 8; i++)
      begin
        cmd = (i == 0) ? 6'h3F : $random(seed);
        pin = (i == 1) ? 6'h3F : $random(seed);
        pins(pin);
        xf({2'h2, cmd});
        chk("mix", {2'h0, mix(cmd, pin, g[0])}, {2'h0, channel_output});
      end
      $display("matrix mode %0d done", g);
    end
    xf(8'h80);
    pins(6'h00);
    xf(8'hC0);
    xf(8'hE4);
    xf(8'hA0);
    xf(8'h80);
    chk("latch", 8'h20, {2'h0, channel_output});
    rd(8'h60);
    chk("hw on", 8'h6C, {1'b0, rx[6:0]});
    xf(8'hE0);
    chk("unlatch", 8'h00, {2'h0, channel_output});
    rd(8'h60);
    chk("hw off", 8'h62, {1'b0, rx[6:0]});
    $display("latch done");
    xf(8'hC5);
    xf(8'h81);
    pins(6'h01);
    xf(8'hE2);
    chk("keep", 8'h01, {2'h0, channel_output});
    chk("led rst", 8'h00, {5'h00, led_load_select});
    xf(8'h60);
    chk("rst ans", 8'h00, {1'b0, rx[6:0]});
    xf(8'h00);
    chk("rst hw", 8'h19, {3'h0, rx[6:2]});
    $display("reset command done");
    pin = $random(seed);
    pins(pin);
    @(posedge clk) #1 limp_home_input = 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("limp", {2'h0, pin}, {2'h0, channel_output});
    xf(8'hC7);
    chk("limp led", 8'h00, {5'h00, led_load_select});
    rd(8'h40);
    chk("limp rd", 8'h40, {1'b0, rx[6:0]});
    @(posedge clk) #1 limp_home_input = 1'b0;
    repeat (10) @(posedge clk);
    $display("limp home done");
    results();
  end
endmodule
bind scc_top scc_top_asserts scc_top_asserts_inst (.clk(clk),
  .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .channel_input_pin(channel_input_pin),
  .limp_home_input(limp_home_input), .channel_output(channel_output),
  .led_load_select(led_load_select));

// ---- core/scc_pkg.sv ----
// Constants shared by the switch channel configuration control block.
// Assumes one 100 MHz clock and a serial host framing 8-bit words.
package scc_pkg;

  localparam int unsigned CHANNELS   = 6;
  localparam int unsigned FRAME_BITS = 8;

  // Frame field positions.
  localparam int unsigned POS_WRITE = 7;
  localparam int unsigned POS_BANK  = 6;
  localparam int unsigned POS_ADDR  = 4;

  // Register addresses inside bank one.
  localparam logic [1:0] ADDR_LOAD_TYPE = 2'h0;
  localparam logic [1:0] ADDR_HW_CONFIG = 2'h2;

  // Hardware configuration register bit positions.
  localparam int unsigned HW_CONTROL = 0;
  localparam int unsigned HW_RST     = 1;
  localparam int unsigned HW_STANDBY = 1;
  localparam int unsigned HW_LATCH   = 2;
  localparam int unsigned HW_CRANK   = 3;

  // Load type register: LED select bits and the input gating mode bit.
  localparam int unsigned LED_CHANNELS = 3;
  localparam int unsigned LT_GATE      = 3;
  localparam int unsigned CRANK_CH     = 5;

  // Reset values.
  localparam logic [5:0] OUT_RESET     = 6'h00;
  localparam logic [2:0] LED_RESET     = 3'h0;
  localparam logic       GATE_RESET    = 1'b0;
  localparam logic       CONTROL_RESET = 1'b0;
  localparam logic       LATCH_RESET   = 1'b1;

endpackage

// ---- core/scc_serial_port.sv ----
// Serial slave that shifts 8-bit frames in and out, MSB first.
// Assumes its pin inputs are already synchronised to clk.
module scc_serial_port
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Synchronised serial pins
  input  wire logic                  sclk_s,
  input  wire logic                  cs_n_s,
  input  wire logic                  mosi_s,
  output logic                       miso,
  output logic                       miso_oe,
  // Frame data
  input  wire logic [FRAME_BITS-1:0] tx_word,
  output logic [FRAME_BITS-1:0]      rx_word,
  output logic                       frame_done
);

  logic                  sclk_d;
  logic                  cs_n_d;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [3:0]            bit_count;

  // Edge history of the synchronised pins.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  // Receive shifting on rising clock edges.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shift_in  <= '0;
      bit_count <= 4'h0;
    end
    else if (cs_n_s)
      bit_count <= 4'h0;
    else if (sclk_s && !sclk_d)
    begin
      shift_in  <= {shift_in[FRAME_BITS-2:0], mosi_s};
      bit_count <= bit_count + 4'h1;
    end
  end

  // Transmit shifting on falling clock edges, loaded at frame start.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      shift_out <= '0;
    else if (cs_n_d && !cs_n_s)
      shift_out <= tx_word;
    else if (!cs_n_s && !sclk_s && sclk_d)
      shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
  end

  // A frame counts only when the 4-bit bit count, which wraps at 16, reads eight.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_word    <= '0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (!cs_n_d && cs_n_s && bit_count == 4'(FRAME_BITS))
      begin
        rx_word    <= shift_in;
        frame_done <= 1'b1;
      end
    end
  end

  assign miso    = shift_out[FRAME_BITS-1];
  assign miso_oe = !cs_n_s;

endmodule

// ---- core/scc_top.sv ----
// Register bank and input switch matrix of a six-channel high-side switch.
// Assumes a serial host, channel pins and limp home pin from outside clk.
// How it works
// (R1) Writing 1 to the reset bit of the configuration register runs a reset.
// (R2) Reading bit 1 of the configuration register gives the stand-by flag.
// (R3) Bit 2 of the configuration register selects latch mode for channel 5.
// (R4) Reading bit 3 gives channel 5 state, and writes put 0 there.
// (R5) Six channels each switch on from their pin or their command bit.
// (R6) Only channels 0 to 2 have a bulb or LED load type setting.
// (R7) The host changes a load type only while that channel is off.
// (R8) With gating mode 0 a channel is on when its bit OR its pin is high.
// (R9) With gating mode 1 a channel is on when its bit AND its pin are high.
// (R10) The reset command returns every register to its default.
// (R11) Only power-on reset clears the channel outputs directly; a register reset clears out_cmd, which they follow.
// (R12) In latch mode channel 5 stays on once commanded until latch is off or limp home starts.
// (R13) In limp home writes are ignored, reads work, pins drive channels.
module scc_top
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Serial host pins
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  output logic                     miso,
  output logic                     miso_oe,
  // Channel pins
  input  wire logic [CHANNELS-1:0] channel_input_pin,
  input  wire logic                limp_home_input,
  output logic [CHANNELS-1:0]      channel_output,
  output logic [LED_CHANNELS-1:0]  led_load_select
);

  logic [CHANNELS-1:0]   pin_m;
  logic [CHANNELS-1:0]   pin_s;
  logic [2:0]            ser_m;
  logic [2:0]            ser_s;
  logic                  limp_m;
  logic                  limp_s;
  logic [FRAME_BITS-1:0] rx_word;
  logic                  frame_done;
  logic [FRAME_BITS-1:0] tx_word;
  logic [CHANNELS-1:0]   out_cmd;
  logic                  input_gate_mode;
  logic                  control_bit_zero;
  logic                  crank_latch_enable;
  logic                  crank_latched;
  logic                  standby_flag;
  logic                  soft_reset;
  logic                  bank_rst;
  logic                  wr_ok;
  logic                  bank_select_bit;
  logic [1:0]            addr;
  logic                  rd_bank;
  logic [1:0]            rd_addr;
  logic [CHANNELS-1:0]   next_output;
  logic [CHANNELS-1:0]   command;

  // Two-stage synchronisers for every pin input.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_m  <= '0;
      pin_s  <= '0;
      ser_m  <= 3'h2;
      ser_s  <= 3'h2;
      limp_m <= 1'b0;
      limp_s <= 1'b0;
    end
    else
    begin
      pin_m  <= channel_input_pin;
      pin_s  <= pin_m;
      ser_m  <= {sclk, cs_n, mosi};
      ser_s  <= ser_m;
      limp_m <= limp_home_input;
      limp_s <= limp_m;
    end
  end

  scc_serial_port u_port
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .sclk_s     (ser_s[2]),
    .cs_n_s     (ser_s[1]),
    .mosi_s     (ser_s[0]),
    .miso       (miso),
    .miso_oe    (miso_oe),
    .tx_word    (tx_word),
    .rx_word    (rx_word),
    .frame_done (frame_done)
  );

  assign bank_select_bit = rx_word[POS_BANK];
  assign addr            = rx_word[POS_ADDR+1:POS_ADDR];
  assign wr_ok           = frame_done && rx_word[POS_WRITE] && !limp_s; // R13
  assign soft_reset      = wr_ok && bank_select_bit
                           && addr == ADDR_HW_CONFIG
                           && rx_word[HW_RST]; // R1
  assign bank_rst        = sys_rst || soft_reset || limp_s; // R10

  // Output command register, bank zero.
  always_ff @(posedge clk)
  begin
    if (bank_rst)
      out_cmd <= OUT_RESET; // R10
    else if (wr_ok && !bank_select_bit)
      out_cmd <= rx_word[CHANNELS-1:0];
  end

  // Load type register; the host only changes it on an idle channel.
  always_ff @(posedge clk)
  begin
    if (bank_rst)
    begin
      led_load_select <= LED_RESET;
      input_gate_mode <= GATE_RESET;
    end
    else if (wr_ok && bank_select_bit && addr == ADDR_LOAD_TYPE)
    begin
      led_load_select <= rx_word[LED_CHANNELS-1:0]; // R6 R7
      input_gate_mode <= rx_word[LT_GATE];
    end
  end

  // Hardware configuration register.
  always_ff @(posedge clk)
  begin
    if (bank_rst)
    begin
      control_bit_zero   <= CONTROL_RESET;
      crank_latch_enable <= LATCH_RESET;
    end
    else if (wr_ok && bank_select_bit && addr == ADDR_HW_CONFIG)
    begin
      control_bit_zero   <= rx_word[HW_CONTROL];
      crank_latch_enable <= rx_word[HW_LATCH]; // R3
    end
  end

  // Read selection, defaulting to the output command register.
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_reset)
    begin
      rd_bank <= 1'b0;
      rd_addr <= 2'h0;
    end
    else if (frame_done && !rx_word[POS_WRITE])
    begin
      rd_bank <= bank_select_bit;
      rd_addr <= addr;
    end
  end

  always_comb
  begin
    tx_word = '0;
    if (!rd_bank)
      tx_word[CHANNELS-1:0] = out_cmd;
    else
    begin
      tx_word[POS_BANK]               = 1'b1;
      tx_word[POS_ADDR+1:POS_ADDR]    = rd_addr;
      if (rd_addr == ADDR_HW_CONFIG)
      begin
        tx_word[HW_CONTROL] = control_bit_zero;
        tx_word[HW_STANDBY] = standby_flag; // R2
        tx_word[HW_LATCH]   = crank_latch_enable;
        tx_word[HW_CRANK]   = channel_output[CRANK_CH]; // R4
      end
      else if (rd_addr == ADDR_LOAD_TYPE)
      begin
        tx_word[LED_CHANNELS-1:0] = led_load_select;
        tx_word[LT_GATE]          = input_gate_mode;
      end
    end
  end

  // Input switch matrix, one cell per channel.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_matrix
      always_comb
      begin
        if (limp_s)
          command[ch] = pin_s[ch]; // R13
        else if (input_gate_mode)
          command[ch] = out_cmd[ch] && pin_s[ch]; // R9
        else
          command[ch] = out_cmd[ch] || pin_s[ch]; // R8
        next_output[ch] = command[ch]; // R5
        if (ch == CRANK_CH && !limp_s)
          next_output[ch] = command[ch] || crank_latched; // R12
      end
    end
  endgenerate

  // Channel 5 cranking latch; cleared by power-on reset, limp home or latch mode off.
  always_ff @(posedge clk)
  begin
    if (sys_rst || limp_s)
      crank_latched <= 1'b0;
    else if (crank_latch_enable && command[CRANK_CH])
      crank_latched <= 1'b1; // R12
    else if (!crank_latch_enable)
      crank_latched <= 1'b0;
  end

  // Channel outputs cleared directly by power-on reset only; register resets reach them through out_cmd.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      channel_output <= '0;
    else
      channel_output <= next_output; // R11
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      standby_flag <= 1'b0;
    else
      standby_flag <= !limp_s && channel_output == '0; // R2
  end

endmodule
